// ==== rtl/mpsc_defines.vh ====
// Constants for the MCU power state controller
`ifndef MPSC_DEFINES_VH
`define MPSC_DEFINES_VH
// Register byte addresses
`define MPSC_ADDR_CTRL       12'h000
`define MPSC_ADDR_STATUS     12'h004
`define MPSC_ADDR_SLPREQ     12'h008
// Control register fields
`define MPSC_CTRL_TOSC_EN    0
`define MPSC_CTRL_TURBO      1
`define MPSC_CTRL_RST        32'h0000_0000
// Sleep request encodings
`define MPSC_REQ_LIGHT       2'h0
`define MPSC_REQ_REGULAR     2'h1
`define MPSC_REQ_DEEP        2'h2
// State codes
`define MPSC_ST_POWER_UP_STATE        3'h0
`define MPSC_ST_ACTIVE       3'h1
`define MPSC_ST_LIGHT        3'h2
`define MPSC_ST_REGULAR      3'h3
`define MPSC_ST_DEEP         3'h4
`define MPSC_ST_RAMP         3'h5
`define MPSC_ST_WAKE         3'h6
// Run level frequencies in MHz
`define MPSC_RUN_LOW_MHZ     20
`define MPSC_RUN_HIGH_MHZ    50
// Cycles a new state waits before trusting synchronised flags
`define MPSC_SETTLE_CYCLES   2'h3
`endif

// ==== rtl/mpsc_sync.v ====
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module mpsc_sync #(
  parameter WIDTH = 3                   // Number of bits
) (
  input  wire             i_clk,        // System clock
  input  wire             i_rst,        // Synchronous reset, active high
  input  wire [WIDTH-1:0] i_async,      // Asynchronous levels
  output wire [WIDTH-1:0] o_sync        // Synchronised levels
);
  reg [WIDTH-1:0] meta_r;               // First stage, read only by second
  reg [WIDTH-1:0] sync_r;               // Second stage

  // Shift through two stages
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

// ==== rtl/mpsc_power_ctrl.v ====
// MCU power state sequencer with APB register slave
`timescale 1ns/1ps
`include "mpsc_defines.vh"
module mpsc_power_ctrl (
  input  wire        i_clk,             // System clock, 10 MHz
  input  wire        i_rst,             // Synchronous reset, active high
  input  wire [11:0] i_paddr,           // APB address
  input  wire        i_psel,            // APB select
  input  wire        i_penable,         // APB enable
  input  wire        i_pwrite,          // APB write
  input  wire [31:0] i_pwdata,          // APB write data
  output wire [31:0] o_prdata,          // APB read data
  output wire        o_pready,          // APB ready
  output wire        o_pslverr,         // APB error
  input  wire        i_sleep_instr,     // CPU executed sleep, one pulse
  input  wire [1:0]  i_sleep_type,      // Requested sleep depth
  input  wire        i_other_reset,     // Another reset source asserted
  input  wire        i_irq_valid,       // Valid interrupt pending
  input  wire        i_dma_req,         // Host interface DMA request
  input  wire        i_chip_busy,       // Chip activity present
  input  wire        i_core_busy,       // Core activity present
  input  wire        i_power_good,      // Analog power good, async
  input  wire        i_sysosc_stable,   // System oscillator stable, async
  input  wire        i_reg_stable,      // Regulator stable, async
  output reg         o_digital_reset,   // Holds digital modules in reset
  output reg         o_cpu_halt,        // Processor halted
  output reg         o_sysosc_en,       // System oscillator enable
  output reg         o_tosc_en,         // Timer oscillator enable
  output reg         o_sysclk_en,       // System clock to digital modules
  output reg         o_turbo,           // Run level: 1 = 50 MHz, 0 = 20 MHz
  output reg         o_ramp_req,        // Retune regulator and oscillator
  output reg  [2:0]  o_state            // Current power state
);
  // State codes
  localparam [2:0] ST_POWER_UP_STATE   = `MPSC_ST_POWER_UP_STATE;    // power_up_state
  localparam [2:0] ST_ACTIVE  = `MPSC_ST_ACTIVE;   // active_state
  localparam [2:0] ST_LIGHT   = `MPSC_ST_LIGHT;    // light_sleep_state
  localparam [2:0] ST_REGULAR = `MPSC_ST_REGULAR;  // regular_sleep_state
  localparam [2:0] ST_DEEP    = `MPSC_ST_DEEP;     // deep_sleep_state
  localparam [2:0] ST_RAMP    = `MPSC_ST_RAMP;     // Ramping
  localparam [2:0] ST_WAKE    = `MPSC_ST_WAKE;     // Oscillator restarting
  localparam [31:0] CTRL_RST  = `MPSC_CTRL_RST;    // Control register reset value

  reg  [2:0]  state_r;                  // Current state
  reg  [2:0]  state_nxt;                // Next state
  reg  [1:0]  req_r;                    // Latched sleep request
  reg  [1:0]  req_nxt;                  // Next sleep request
  reg         deep_wake_r;              // Wake came from deep sleep
  reg         deep_wake_nxt;            // Next deep-wake flag
  reg         tosc_en_r;                // Firmware timer oscillator enable
  reg         turbo_tgt_r;              // Firmware target run level
  reg         turbo_cur_r;              // Run level in force
  reg         turbo_cur_nxt;            // Next run level
  reg         clr_tosc;                 // Clear timer enable on entry
  reg         ack_r;                    // APB access answered
  reg  [31:0] rdata_r;                  // APB read data
  reg         err_r;                    // APB error
  wire [2:0]  ana_sync;                 // Synchronised analog levels
  wire        pwr_good;                 // Power good
  wire        osc_ok;                   // System oscillator stable
  wire        reg_ok;                   // Regulator stable
  wire        apb_acc;                  // APB access phase
  wire        apb_wr;                   // APB write strobe
  reg  [1:0]  settle_cnt_r;             // Cycles spent in current state
  wire        settle_done;              // Synchronised flags are fresh

  mpsc_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_reg_stable, i_sysosc_stable, i_power_good}),
    .o_sync  (ana_sync)
  );
  assign pwr_good = ana_sync[0];
  assign osc_ok   = ana_sync[1];
  assign reg_ok   = ana_sync[2];

  // Synchronised flags lag by two cycles, so a new state ignores them
  // until the guard count has passed
  assign settle_done = (settle_cnt_r == `MPSC_SETTLE_CYCLES);

  // Cycles spent in the current state, saturating at the guard
  always @(posedge i_clk) begin
    if (i_rst) begin
      settle_cnt_r <= 2'h0;
    end else if (state_nxt != state_r) begin
      // Restart on every state change
      settle_cnt_r <= 2'h0;
    end else if (!settle_done) begin
      // Count up to the guard
      settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end

  // Address match helper
  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a[11:2] == b[11:2]);
    end
  endfunction

  // APB strobes, answer one cycle after the first access cycle
  assign apb_acc   = i_psel & i_penable;
  assign apb_wr    = apb_acc & i_pwrite & ~ack_r;
  assign o_pready  = ack_r;
  assign o_prdata  = rdata_r;
  assign o_pslverr = err_r;

  // Next state logic
  always @* begin
    // Hold everything unless a branch moves it
    state_nxt     = state_r;
    req_nxt       = req_r;
    deep_wake_nxt = deep_wake_r;
    turbo_cur_nxt = turbo_cur_r;
    clr_tosc      = 1'b0;
    case (state_r)
      ST_POWER_UP_STATE: begin
        if (pwr_good && osc_ok && !i_other_reset) begin
          state_nxt = ST_ACTIVE;
          clr_tosc  = 1'b1;
        end
      end
      ST_ACTIVE: begin
        // sleep only from active on instruction
        if (i_sleep_instr) begin
          req_nxt = i_sleep_type;
          if (!i_chip_busy && i_sleep_type == `MPSC_REQ_DEEP) begin
            state_nxt = ST_DEEP;
          end else if (!i_chip_busy && i_sleep_type == `MPSC_REQ_REGULAR) begin
            state_nxt = ST_REGULAR;
          end else begin
            state_nxt = ST_LIGHT;
          end
        end else if (turbo_tgt_r != turbo_cur_r) begin
          // run level change goes through ramp
          state_nxt = ST_RAMP;
        end
      end
      ST_LIGHT: begin
        if (i_irq_valid) begin
          state_nxt = ST_ACTIVE;
        end else if (req_r == `MPSC_REQ_LIGHT) begin
          state_nxt = ST_LIGHT;
        end else if (!i_core_busy) begin
          if (req_r == `MPSC_REQ_DEEP) begin
            state_nxt = ST_DEEP;
          end else begin
            state_nxt = ST_REGULAR;
          end
        end
      end
      ST_REGULAR, ST_DEEP: begin
        if (i_irq_valid || i_dma_req) begin
          state_nxt     = ST_WAKE;
          deep_wake_nxt = (state_r == ST_DEEP);
          // deep sleep leaves timer enable off
          clr_tosc      = (state_r == ST_DEEP);
        end
      end
      ST_WAKE: begin
        // decide once oscillator stable
        // Guard skips flags sampled before the restart
        if (osc_ok && settle_done) begin
          if (i_irq_valid) begin
            state_nxt = ST_ACTIVE;
            // timer oscillator off after deep sleep
            clr_tosc  = deep_wake_r;
          end else begin
            state_nxt = ST_LIGHT;
            req_nxt   = `MPSC_REQ_LIGHT;
          end
          deep_wake_nxt = 1'b0;
        end
      end
      ST_RAMP: begin
        // leave ramp when both stable
        // Guard skips flags sampled before the retune began
        if (reg_ok && osc_ok && settle_done) begin
          state_nxt     = ST_ACTIVE;
          turbo_cur_nxt = turbo_tgt_r;
        end
      end
      default: begin
        // Unused codes fall back to power-up
        state_nxt = ST_POWER_UP_STATE;
      end
    endcase
  end

  // State registers
  always @(posedge i_clk) begin
    if (i_rst) begin
      // Power-up state, light request
      state_r     <= ST_POWER_UP_STATE;
      req_r       <= `MPSC_REQ_LIGHT;
      deep_wake_r <= 1'b0;
      turbo_cur_r <= 1'b0;
    end else begin
      // Advance to next values
      state_r     <= state_nxt;
      req_r       <= req_nxt;
      deep_wake_r <= deep_wake_nxt;
      turbo_cur_r <= turbo_cur_nxt;
    end
  end

  // Control register and APB answer
  always @(posedge i_clk) begin
    if (i_rst) begin
      // Firmware fields from the register reset value
      tosc_en_r   <= CTRL_RST[`MPSC_CTRL_TOSC_EN];
      turbo_tgt_r <= CTRL_RST[`MPSC_CTRL_TURBO];
      ack_r       <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      err_r       <= 1'b0;
    end else begin
      // Answer every access one cycle later
      ack_r <= apb_acc & ~ack_r;
      err_r <= 1'b0;
      if (clr_tosc) begin
        tosc_en_r <= 1'b0;
      end else if (apb_wr && is_addr(i_paddr, `MPSC_ADDR_CTRL)) begin
        tosc_en_r <= i_pwdata[`MPSC_CTRL_TOSC_EN];
      end
      if (apb_wr && is_addr(i_paddr, `MPSC_ADDR_CTRL)) begin
        turbo_tgt_r <= i_pwdata[`MPSC_CTRL_TURBO];
      end
      // Read data captured on the first access cycle
      if (apb_acc && !ack_r) begin
        rdata_r <= 32'h0000_0000;
        if (is_addr(i_paddr, `MPSC_ADDR_CTRL)) begin
          rdata_r <= {30'h0000_0000, turbo_tgt_r, tosc_en_r};
        end else if (is_addr(i_paddr, `MPSC_ADDR_STATUS)) begin
          rdata_r <= {24'h00_0000, reg_ok, osc_ok, pwr_good, turbo_cur_r, 1'b0, state_r};
        end else if (is_addr(i_paddr, `MPSC_ADDR_SLPREQ)) begin
          rdata_r <= {30'h0000_0000, req_r};
        end else begin
          // Unmapped address answers with error
          err_r <= 1'b1;
        end
      end
    end
  end

  // Output decode from state
  always @(posedge i_clk) begin
    if (i_rst) begin
      // Safe values: digital modules held in reset, CPU halted, system oscillator on
      o_digital_reset <= 1'b1;
      o_cpu_halt      <= 1'b1;
      o_sysosc_en     <= 1'b1;
      o_tosc_en       <= 1'b0;
      o_sysclk_en     <= 1'b0;
      o_turbo         <= 1'b0;
      o_ramp_req      <= 1'b0;
      o_state         <= ST_POWER_UP_STATE;
    end else begin
      // State and run level follow the next state
      o_state         <= state_nxt;
      o_turbo         <= turbo_cur_nxt;
      o_ramp_req      <= (state_nxt == ST_RAMP);
      o_digital_reset <= (state_nxt == ST_POWER_UP_STATE);
      o_cpu_halt      <= (state_nxt != ST_ACTIVE);
      // oscillator off in regular and deep sleep
      o_sysosc_en     <= (state_nxt != ST_REGULAR) && (state_nxt != ST_DEEP);
      // system clock only in active and light sleep
      o_sysclk_en     <= (state_nxt == ST_ACTIVE) || (state_nxt == ST_LIGHT);
      if (state_nxt != ST_RAMP) begin
        // timer oscillator off in deep sleep and power-up
        o_tosc_en     <= tosc_en_r && !clr_tosc && (state_nxt != ST_DEEP)
                         && (state_nxt != ST_POWER_UP_STATE);
      end
    end
  end
endmodule

// ==== bench/mpsc_power_ctrl_assertions.sv ====
// Port assertions for the power state controller
`timescale 1ns/1ps
module mpsc_power_ctrl_assertions (
  input wire       i_clk,           // Clock
  input wire       i_rst,           // Reset
  input wire       i_sleep_instr,   // Sleep
  input wire       i_chip_busy,     // Busy
  input wire       i_irq_valid,     // Irq
  input wire       i_reg_stable,    // Reg ok
  input wire       o_digital_reset, // Hold
  input wire       o_sysosc_en,     // Osc
  input wire       o_tosc_en,       // Timer osc
  input wire       o_sysclk_en,     // Sys clock
  input wire       o_turbo,         // Level
  input wire [2:0] o_state          // State
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_pu; o_state == 3'h0 |-> o_digital_reset && !o_tosc_en; endproperty
  a_pu: assert property (p_pu) else $error("power-up outputs wrong");
  property p_bz; o_state == 3'h1 && i_sleep_instr && i_chip_busy |=> o_state == 3'h2; endproperty
  a_bz: assert property (p_bz) else $error("busy sleep not light");
  property p_wk; o_state == 3'h2 && i_irq_valid |=> o_state == 3'h1; endproperty
  a_wk: assert property (p_wk) else $error("light sleep wake");
  property p_os; o_state == 3'h3 || o_state == 3'h4 |-> !o_sysosc_en; endproperty
  a_os: assert property (p_os) else $error("osc on in sleep");
  property p_dp; o_state == 3'h4 |-> !o_tosc_en; endproperty
  a_dp: assert property (p_dp) else $error("timer osc on in deep");
  property p_lv; $changed(o_turbo) |-> $past(o_state) == 3'h5 || $past(o_state, 2) == 3'h5; endproperty
  a_lv: assert property (p_lv) else $error("level change off ramp");
  property p_rp; o_state == 3'h5 |-> !o_sysclk_en && $stable(o_tosc_en); endproperty
  a_rp: assert property (p_rp) else $error("ramp clocks");
  property p_re; (o_state == 3'h5 && !i_reg_stable)[*3] |=> o_state == 3'h5; endproperty
  a_re: assert property (p_re) else $error("ramp left early");
endmodule

// ==== bench/mpsc_analog_model.sv ====
// Analog model: oscillator and regulator settling
`timescale 1ns/1ps
module mpsc_analog_model (
  input  wire       i_clk,    // Clock
  input  wire       i_rst,    // Reset
  input  wire [3:0] i_dly,    // Settle cycles
  input  wire       i_osc_en, // Osc enable
  input  wire       i_ramp,   // Retune request
  output wire       o_osc_ok, // Osc stable
  output wire       o_reg_ok  // Regulator stable
);
  logic [3:0] cnt_r;  // Settle countdown
  logic       ramp_q; // Last retune request
  wire        kick = i_ramp && !ramp_q; // New retune drops both at once
  // Restart settling when the oscillator stops or a retune begins
  always @(posedge i_clk) begin
    ramp_q <= i_ramp;
    if (i_rst || !i_osc_en || kick)
      cnt_r <= i_dly;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  assign o_osc_ok = i_osc_en && cnt_r == 4'h0 && !kick;
  assign o_reg_ok = cnt_r == 4'h0 && !kick;
endmodule

// ==== bench/mcu_power_state_controller_bench.sv ====
// Self-checking bench for the power state controller
`timescale 1ns/1ps
module mcu_power_state_controller_bench;
  logic        i_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        o_pready, o_pslverr, er, i_sleep_instr = 1'h0, i_other_reset = 1'h1;
  logic [1:0]  i_sleep_type = 2'h0;
  logic        i_irq_valid = 1'h0, i_dma_req = 1'h0, i_core_busy = 1'h0, i_chip_busy = 1'h0;
  logic        i_power_good = 1'h0, i_sysosc_stable, i_reg_stable, o_digital_reset;
  logic        o_cpu_halt, o_sysosc_en, o_tosc_en, o_sysclk_en, o_turbo, o_ramp_req;
  logic [2:0]  o_state;
  logic [3:0]  dly = 4'h2; // Analog settle cycles
  int          num_errors = 0;
  int          check_count = 0;
  // Clock at 10 MHz
  always #50 i_clk = ~i_clk;
  mpsc_power_ctrl dut_u (.i_clk, .i_rst, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_sleep_instr, .i_sleep_type, .i_other_reset,
    .i_irq_valid, .i_dma_req, .i_chip_busy, .i_core_busy, .i_power_good, .i_sysosc_stable,
    .i_reg_stable, .o_digital_reset, .o_cpu_halt, .o_sysosc_en, .o_tosc_en, .o_sysclk_en,
    .o_turbo, .o_ramp_req, .o_state);
  mpsc_analog_model ana_u (.i_clk, .i_rst, .i_dly(dly), .i_osc_en(o_sysosc_en),
    .i_ramp(o_ramp_req), .o_osc_ok(i_sysosc_stable), .o_reg_ok(i_reg_stable));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Wait for a state, bounded
  task wst(input logic [2:0] s);
    @(negedge i_clk);
    for (int n = 0; n < 60 && o_state !== s; n++) @(negedge i_clk);
    chk(o_state, s);
  endtask
  // APB transfer: held until ready is sampled high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'h1, w, a, d};
    @(posedge i_clk);
    i_penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1) @(posedge i_clk);
    {rd, er} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'h0;
  endtask
  task sleep(input logic [1:0] t);
    @(posedge i_clk);
    {i_sleep_instr, i_sleep_type} <= {1'h1, t};
    @(posedge i_clk);
    i_sleep_instr <= 1'h0;
  endtask
  // Set irq, dma, core busy, chip busy
  task ev(input logic [3:0] v);
    @(posedge i_clk);
    {i_irq_valid, i_dma_req, i_core_busy, i_chip_busy} <= v;
  endtask
  task t_power_up_state;
    repeat (8) @(negedge i_clk);
    chk(o_state, 3'h0);
    chk(o_digital_reset, 1'h1);
    @(posedge i_clk);
    i_other_reset <= 1'h0;
    wst(3'h1);
    chk(o_tosc_en, 1'h0);
  endtask
  task t_regs;
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0000_00E1);
    apb(1'h1, 12'h000, 32'h1);
    wst(3'h1);
    chk(o_tosc_en, 1'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'h0, 12'h00C, 32'h0);
    chk(er, 1'h1);
  endtask
  task t_ramp;
    dly <= 4'hC;
    apb(1'h1, 12'h000, 32'h3);
    wst(3'h5);
    chk(o_ramp_req, 1'h1);
    chk({o_sysclk_en, o_tosc_en}, 2'h1);
    wst(3'h1);
    chk({o_turbo, o_sysclk_en}, 2'h3);
    dly <= 4'h2;
    apb(1'h1, 12'h000, 32'h1);
    wst(3'h5);
    wst(3'h1);
    chk(o_turbo, 1'h0);
  endtask
  task t_sleep;
    ev(4'h1);
    sleep(2'h0);
    wst(3'h2);
    sleep(2'h2);
    chk(o_state, 3'h2);
    repeat (8) @(negedge i_clk);
    chk({o_state, o_cpu_halt, o_sysosc_en}, 5'h0B);
    ev(4'h9);
    wst(3'h1);
    ev(4'h3);
    sleep(2'h1);
    wst(3'h2);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0001);
    ev(4'h1);
    wst(3'h3);
    chk(o_sysosc_en, 1'h0);
    ev(4'h7);
    wst(3'h6);
    ev(4'h3);
    wst(3'h2);
    ev(4'hB);
    wst(3'h1);
  endtask
  task t_deep;
    ev(4'h0);
    sleep(2'h2);
    @(negedge i_clk);
    chk({o_state, o_tosc_en, o_sysosc_en}, 5'h10);
    ev(4'h8);
    wst(3'h1);
    chk(o_tosc_en, 1'h0);
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    {i_rst, i_power_good} <= 2'h1;
    t_power_up_state;
    t_regs;
    t_ramp;
    t_sleep;
    t_deep;
    final_report;
  end
  // Watchdog
  initial begin
    repeat (9000) @(posedge i_clk);
    num_errors++;
    final_report;
  end
endmodule
bind mpsc_power_ctrl mpsc_power_ctrl_assertions chk_u (.i_clk, .i_rst, .i_sleep_instr,
  .i_chip_busy, .i_irq_valid, .i_reg_stable, .o_digital_reset, .o_sysosc_en, .o_tosc_en,
  .o_sysclk_en, .o_turbo, .o_state);
